//--- design/htrc_pkg.sv
package htrc_pkg;
   // register pointers
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_MEAS_HIGH = 8'h01;
   localparam logic [7:0] ADDR_MEAS_LOW = 8'h02;
   localparam logic [7:0] ADDR_SETUP = 8'h03;
   localparam logic [7:0] ADDR_SIGNATURE = 8'h11;
   // reset values
   localparam logic [7:0] STATUS_RESET = 8'h01;
   localparam logic [7:0] MEAS_RESET = 8'h00;
   localparam logic [7:0] SETUP_RESET = 8'h00;
   // conversion_setup field positions
   localparam int SETUP_FAST_BIT = 5;
   localparam int SETUP_TEMP_BIT = 4;
   localparam int SETUP_WARMING_ELEMENT_ON_BIT = 1;
   localparam int SETUP_START_BIT = 0;
   localparam logic [7:0] SETUP_WRITE_MASK = 8'h33;
   // bus address
   localparam logic [6:0] SLAVE_ADDR = 7'h40;
   // signature: arbitrary neutral values
   localparam logic [3:0] SIG_TYPE = 4'ha;
   localparam logic [3:0] SIG_REV = 4'h3;
   // conversion times
   localparam int CLK_MHZ = 100;
   localparam int T_NORMAL_MS = 35;
   localparam int T_FAST_MS = 18;
   localparam int CYC_NORMAL = T_NORMAL_MS * 1000 * CLK_MHZ;
   localparam int CYC_FAST = T_FAST_MS * 1000 * CLK_MHZ;

   typedef struct packed {
      logic fast;
      logic temp;
   } htrc_conv_s;
endpackage : htrc_pkg

//--- design/htrc_top.sv
`timescale 1ns/1ps
// Contract
// R1 - host writes only the five defined register addresses
// R2 - reserved bits written zero by host; device reads them as zero
// R3 - status bit 0 reads 1 while converting, 0 when result ready
// R4 - address 1 returns the result's upper eight bits
// R5 - address 2 returns the result's lower eight bits
// R6 - setup bit 5 picks fast (18 ms) or normal (35 ms) conversion
// R7 - setup bit 4 picks temperature (1) or humidity (0)
// R8 - setup bit 1 drives the heater output
// R9 - writing 1 to setup bit 0 starts a conversion; 0 does not
// R10 - host may raise select to put device in standby
// R11 - start sets not-ready; data loaded at end, then flag clears
// R12 - signature at address 17: type high nibble, revision low nibble
// R13 - select active low; bus answered only while low
// R14 - slave address 0x40; pointer then data; read after repeated start
// R15 - result read high then low on host ack; host nacks last, stops
module htrc_top #(
   parameter int CONV_NORMAL_CYC = htrc_pkg::CYC_NORMAL,
   parameter int CONV_FAST_CYC = htrc_pkg::CYC_FAST
) (
   // system
   input wire logic clk_sys,
   input wire logic resetn,
   // bus pins, taken as synchronous samples
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic select_n,
   // sensing core
   input wire logic [15:0] sample_value,
   output logic warming_element_on,
   output logic meas_temp,
   output logic meas_fast,
   output logic converting
);
   typedef enum logic [2:0] {
      HTRC_IDLE = 3'b000,
      HTRC_ADDR = 3'b001,
      HTRC_PTR = 3'b010,
      HTRC_WDATA = 3'b011,
      HTRC_RDATA = 3'b100,
      HTRC_MACK = 3'b101,
      HTRC_SACK = 3'b110,
      HTRC_SKIP = 3'b111
   } htrc_state_e;

   // unmapped pointers read as zero, so a stray read is harmless
   function automatic logic [7:0] read_mux(input logic [7:0] ptr, input logic [7:0] st,
                                           input logic [7:0] mh, input logic [7:0] ml,
                                           input logic [7:0] cs);
      logic [7:0] v;
      v = 8'h00;
      unique case (ptr)
         htrc_pkg::ADDR_STATUS: v = st;
         htrc_pkg::ADDR_MEAS_HIGH: v = mh; // see R4
         htrc_pkg::ADDR_MEAS_LOW: v = ml; // see R5
         htrc_pkg::ADDR_SETUP: v = cs;
         htrc_pkg::ADDR_SIGNATURE: v = {htrc_pkg::SIG_TYPE, htrc_pkg::SIG_REV}; // see R12
         default: v = 8'h00;
      endcase
      return v;
   endfunction : read_mux

   htrc_state_e state_reg, state_next;
   htrc_state_e after_ack_reg, after_ack_next;
   logic scl_reg, sda_reg;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] ptr_reg, ptr_next;
   logic [7:0] setup_reg, setup_next;
   logic [7:0] meas_high_reg, meas_high_next;
   logic [7:0] meas_low_reg, meas_low_next;
   logic busy_reg, busy_next;
   logic [31:0] cnt_reg, cnt_next;
   logic sda_drive_reg, sda_drive_next;
   logic start_pulse;
   logic scl_rise, scl_fall, bus_start, bus_stop;
   logic [7:0] status_val;
   logic bus_live;

   assign scl_rise = scl_in & ~scl_reg;
   assign scl_fall = ~scl_in & scl_reg;
   assign bus_start = scl_in & scl_reg & sda_reg & ~sda_in;
   assign bus_stop = scl_in & scl_reg & ~sda_reg & sda_in;
   assign status_val = {7'h00, busy_reg}; // see R3, R2
   // for the checks below: a cycle in which the engine follows its state
   assign bus_live = ~select_n & ~bus_start & ~bus_stop;

   // bus engine
   always_comb begin
      state_next = state_reg;
      after_ack_next = after_ack_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      ptr_next = ptr_reg;
      setup_next = setup_reg;
      sda_drive_next = sda_drive_reg;
      start_pulse = 1'b0;
      if (select_n) begin // see R13
         state_next = HTRC_IDLE;
         sda_drive_next = 1'b0;
      end else if (bus_start) begin // also repeated start, see R14
         state_next = HTRC_ADDR;
         bit_cnt_next = 4'h0;
         sda_drive_next = 1'b0;
      end else if (bus_stop) begin
         state_next = HTRC_IDLE;
         sda_drive_next = 1'b0;
      end else begin
         unique case (state_reg)
            HTRC_IDLE, HTRC_SKIP: begin
            end
            HTRC_ADDR, HTRC_PTR, HTRC_WDATA: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_in};
                  bit_cnt_next = 4'(bit_cnt_reg + 4'h1);
               end
               if (scl_fall && bit_cnt_reg == 4'h8) begin
                  bit_cnt_next = 4'h0;
                  state_next = HTRC_SACK;
                  sda_drive_next = 1'b1;
                  if (state_reg == HTRC_ADDR) begin
                     if (shift_reg[7:1] != htrc_pkg::SLAVE_ADDR) begin // see R14
                        state_next = HTRC_SKIP;
                        sda_drive_next = 1'b0;
                     end else if (shift_reg[0]) begin
                        after_ack_next = HTRC_RDATA;
                        shift_next = read_mux(ptr_reg, status_val, meas_high_reg, meas_low_reg,
                                              setup_reg & htrc_pkg::SETUP_WRITE_MASK);
                     end else begin
                        after_ack_next = HTRC_PTR;
                     end
                  end else if (state_reg == HTRC_PTR) begin
                     ptr_next = shift_reg;
                     after_ack_next = HTRC_WDATA;
                  end else begin
                     // reserved bits dropped; start bit self-clears
                     if (ptr_reg == htrc_pkg::ADDR_SETUP) begin // see R1
                        setup_next = shift_reg & htrc_pkg::SETUP_WRITE_MASK; // see R2
                        setup_next[htrc_pkg::SETUP_START_BIT] = 1'b0;
                        start_pulse = shift_reg[htrc_pkg::SETUP_START_BIT]; // see R9
                     end
                     after_ack_next = HTRC_SKIP;
                  end
               end
            end
            HTRC_SACK: begin
               if (scl_fall) begin
                  state_next = after_ack_reg;
                  sda_drive_next = 1'b0;
                  if (after_ack_reg == HTRC_RDATA) begin
                     sda_drive_next = ~shift_reg[7];
                  end
               end
            end
            HTRC_RDATA: begin
               if (scl_fall) begin
                  bit_cnt_next = 4'(bit_cnt_reg + 4'h1);
                  shift_next = {shift_reg[6:0], 1'b0};
                  sda_drive_next = ~shift_reg[6];
                  if (bit_cnt_reg == 4'h7) begin
                     state_next = HTRC_MACK;
                     sda_drive_next = 1'b0;
                     bit_cnt_next = 4'h0;
                  end
               end
            end
            HTRC_MACK: begin
               if (scl_rise) begin
                  if (sda_in) begin // see R15
                     state_next = HTRC_SKIP;
                  end else begin
                     ptr_next = 8'(ptr_reg + 8'h01);
                     shift_next = read_mux(8'(ptr_reg + 8'h01), status_val, meas_high_reg,
                                           meas_low_reg, setup_reg & htrc_pkg::SETUP_WRITE_MASK);
                     after_ack_next = HTRC_RDATA;
                     state_next = HTRC_SACK; // waits for fall, then drives next byte
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= HTRC_IDLE;
         after_ack_reg <= HTRC_IDLE;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         setup_reg <= htrc_pkg::SETUP_RESET;
         sda_drive_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         after_ack_reg <= after_ack_next;
         scl_reg <= scl_in;
         sda_reg <= sda_in;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         ptr_reg <= ptr_next;
         setup_reg <= setup_next;
         sda_drive_reg <= sda_drive_next;
      end
   end

   // conversion timer; a start while busy restarts the conversion
   always_comb begin
      busy_next = busy_reg;
      cnt_next = cnt_reg;
      meas_high_next = meas_high_reg;
      meas_low_next = meas_low_reg;
      if (start_pulse) begin
         busy_next = 1'b1; // see R11
         cnt_next = setup_next[htrc_pkg::SETUP_FAST_BIT] ? 32'(CONV_FAST_CYC)
                                                         : 32'(CONV_NORMAL_CYC); // see R6
      end else if (busy_reg && cnt_reg != 32'h0) begin
         // a zero count is the reset busy period: no result to load yet
         if (cnt_reg == 32'h1) begin
            meas_high_next = sample_value[15:8]; // see R11
            meas_low_next = sample_value[7:0];
            busy_next = 1'b0;
            cnt_next = 32'h0;
         end else begin
            cnt_next = cnt_reg - 32'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         busy_reg <= htrc_pkg::STATUS_RESET[0];
         cnt_reg <= 32'h0;
         meas_high_reg <= htrc_pkg::MEAS_RESET;
         meas_low_reg <= htrc_pkg::MEAS_RESET;
      end else begin
         busy_reg <= busy_next;
         cnt_reg <= cnt_next;
         meas_high_reg <= meas_high_next;
         meas_low_reg <= meas_low_next;
      end
   end

   htrc_pkg::htrc_conv_s conv;
   assign conv = '{fast: setup_reg[htrc_pkg::SETUP_FAST_BIT], temp: setup_reg[htrc_pkg::SETUP_TEMP_BIT]};
   assign meas_fast = conv.fast; // see R6
   assign meas_temp = conv.temp; // see R7
   assign warming_element_on = setup_reg[htrc_pkg::SETUP_WARMING_ELEMENT_ON_BIT]; // see R8
   assign converting = busy_reg;
   // open drain: the pin is only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe = sda_drive_reg;

   // reset leaves busy set until the first conversion ends
   start_sets_busy_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R11
      start_pulse |=> busy_reg && cnt_reg != 32'h0) else $error("start did not set busy");
   busy_holds_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R11
      busy_reg && !start_pulse && cnt_reg != 32'h1 |=> busy_reg) else $error("busy dropped early");
   ready_at_end_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R3
      $fell(busy_reg) |-> $past(cnt_reg) == 32'h1) else $error("ready before count ran out");
   done_loads_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R4, R5
      $fell(busy_reg) |-> {meas_high_reg, meas_low_reg} == $past(sample_value)) else $error("data not loaded");
   fast_load_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R6
      start_pulse && setup_next[5] |=> cnt_reg == 32'(CONV_FAST_CYC)) else $error("fast count wrong");
   normal_load_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R6
      start_pulse && !setup_next[5] |=> cnt_reg == 32'(CONV_NORMAL_CYC)) else $error("normal count");
   start_on_write_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R9
      start_pulse |-> state_reg == HTRC_WDATA && ptr_reg == htrc_pkg::ADDR_SETUP
                      && shift_reg[htrc_pkg::SETUP_START_BIT]) else $error("start without a write");
   no_start_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R9
      !start_pulse && !busy_reg |=> !busy_reg) else $error("spurious start");
   setup_clean_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R2
      (setup_reg & ~htrc_pkg::SETUP_WRITE_MASK) == 8'h00 && !setup_reg[htrc_pkg::SETUP_START_BIT])
      else $error("reserved setup bit set");
   warming_element_on_write_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R8
      $changed(warming_element_on) |-> $past(state_reg) == HTRC_WDATA
                                       && $past(ptr_reg) == htrc_pkg::ADDR_SETUP)
      else $error("heater moved without a write");
   mode_write_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R6, R7
      $changed(meas_temp) || $changed(meas_fast) |-> $past(state_reg) == HTRC_WDATA
                                                     && $past(ptr_reg) == htrc_pkg::ADDR_SETUP)
      else $error("mode moved without a write");
   // bus side
   deselect_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R13
      select_n |=> !sda_oe) else $error("drove bus while deselected");
   idle_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R14
      state_reg == HTRC_IDLE || state_reg == HTRC_SKIP |-> !sda_oe) else $error("drove bus while idle");
   ack_on_match_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R14
      bus_live && state_reg == HTRC_ADDR && scl_fall && bit_cnt_reg == 4'h8
      && shift_reg[7:1] == htrc_pkg::SLAVE_ADDR |=> sda_oe) else $error("own address not acked");
   other_addr_skip_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R14
      bus_live && state_reg == HTRC_ADDR && scl_fall && bit_cnt_reg == 4'h8
      && shift_reg[7:1] != htrc_pkg::SLAVE_ADDR |=> !sda_oe && state_reg == HTRC_SKIP)
      else $error("foreign address acked");
   nack_ends_read_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R15
      bus_live && state_reg == HTRC_MACK && scl_rise && sda_in |=> state_reg == HTRC_SKIP && !sda_oe)
      else $error("read went on after nack");
   ack_next_byte_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R15
      bus_live && state_reg == HTRC_MACK && scl_rise && !sda_in |=> ptr_reg == 8'($past(ptr_reg) + 8'h01))
      else $error("pointer did not advance");
endmodule : htrc_top

//--- tb/htrc_host.sv
`timescale 1ns/1ps
module htrc_host (
   // system
   input wire logic clk_sys,
   // bus wires
   input wire logic sda_w,
   output logic scl_in,
   output logic sda_h
);
   // lines released to their pull-ups until the first transfer
   initial begin
      scl_in = 1'b1;
      sda_h = 1'b1;
   end
   task automatic hc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : hc
   // serves as start and repeated start; every scl level lasts at least 4 cycles
   task automatic start();
      hc(2);
      sda_h <= 1'b1;
      hc(2);
      scl_in <= 1'b1;
      hc(4);
      sda_h <= 1'b0;
      hc(4);
      scl_in <= 1'b0;
   endtask : start
   task automatic stop();
      hc(2);
      sda_h <= 1'b0;
      hc(2);
      scl_in <= 1'b1;
      hc(4);
      sda_h <= 1'b1;
      hc(4);
   endtask : stop
   // data moves only while scl is low, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      hc(2);
      sda_h <= b;
      hc(2);
      scl_in <= 1'b1;
      hc(2);
      r = sda_w;
      hc(2);
      scl_in <= 1'b0;
   endtask : bit_io
   // ninth bit: 1 releases for the device ack, 0 acks a read byte
   task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(nine, a);
   endtask : xfer
endmodule : htrc_host

//--- tb/tb_htrc_top.sv
`timescale 1ns/1ps
module tb_htrc_top;
   localparam int NC = 1500;
   localparam int FC = 900;
   logic clk_sys;
   logic resetn;
   logic select_n;
   logic [15:0] sample_value;
   logic scl_in;
   logic sda_h;
   wire logic sda_w;
   logic sda_out;
   logic sda_oe;
   logic warming_element_on;
   logic meas_temp;
   logic meas_fast;
   logic converting;
   int failures;
   int n_checks;
   int hi_cnt;
   int last_len;
   logic [7:0] hi;
   logic [7:0] lo;
   logic [7:0] st;
   logic [15:0] prev;
   // open drain with pull-up
   assign sda_w = sda_h & ~(sda_oe & ~sda_out);
   htrc_top #(.CONV_NORMAL_CYC(NC), .CONV_FAST_CYC(FC)) uut (.clk_sys(clk_sys), .resetn(resetn),
      .scl_in(scl_in), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .select_n(select_n),
      .sample_value(sample_value), .warming_element_on(warming_element_on), .meas_temp(meas_temp),
      .meas_fast(meas_fast), .converting(converting));
   htrc_host h (.clk_sys(clk_sys), .sda_w(sda_w), .scl_in(scl_in), .sda_h(sda_h));
   always #5 clk_sys = ~clk_sys;
   // length of the last busy period
   always @(posedge clk_sys) begin
      if (converting === 1'b1) begin
         hi_cnt <= hi_cnt + 1;
      end else begin
         if (hi_cnt != 0) last_len <= hi_cnt;
         hi_cnt <= 0;
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict
   // address phase only; exp_ack is the sampled ninth-bit level
   task automatic probe(input logic [6:0] a7, input logic exp_ack);
      logic [7:0] r;
      logic a;
      h.start();
      h.xfer({a7, 1'b0}, 1'b1, r, a);
      chk({7'h00, a}, {7'h00, exp_ack});
      h.stop();
   endtask : probe
   // only defined pointers, reserved bits written zero
   task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] r;
      logic a;
      h.start();
      h.xfer({htrc_pkg::SLAVE_ADDR, 1'b0}, 1'b1, r, a);
      chk({7'h00, a}, 8'h00);
      h.xfer(p, 1'b1, r, a);
      h.xfer(d, 1'b1, r, a);
      h.stop();
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] p, input logic two, output logic [7:0] d0, output logic [7:0] d1);
      logic [7:0] r;
      logic a;
      h.start();
      h.xfer({htrc_pkg::SLAVE_ADDR, 1'b0}, 1'b1, r, a);
      h.xfer(p, 1'b1, r, a);
      h.start();
      h.xfer({htrc_pkg::SLAVE_ADDR, 1'b1}, 1'b1, r, a);
      h.xfer(8'hff, ~two, d0, a);
      d1 = 8'h00;
      if (two) h.xfer(8'hff, 1'b1, d1, a);
      h.stop();
   endtask : reg_rd
   task automatic wait_idle();
      int n;
      n = 0;
      while (converting !== 1'b0 && n < 5000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 5000) begin
         failures++;
         print_verdict();
      end
   endtask : wait_idle
   initial begin
      clk_sys = 1'b0;
      resetn = 1'b0;
      select_n = 1'b0;
      sample_value = 16'h0000;
      failures = 0;
      n_checks = 0;
      hi_cnt = 0;
      last_len = 0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      reg_rd(htrc_pkg::ADDR_STATUS, 1'b0, st, lo);
      chk(st, htrc_pkg::STATUS_RESET);
      reg_rd(htrc_pkg::ADDR_MEAS_HIGH, 1'b1, hi, lo);
      chk(hi, htrc_pkg::MEAS_RESET);
      chk(lo, htrc_pkg::MEAS_RESET);
      reg_rd(htrc_pkg::ADDR_SETUP, 1'b0, st, lo);
      chk(st, htrc_pkg::SETUP_RESET);
      reg_rd(htrc_pkg::ADDR_SIGNATURE, 1'b0, st, lo);
      chk(st, {htrc_pkg::SIG_TYPE, htrc_pkg::SIG_REV});
      probe(7'h41, 1'b1);
      // standby: the host addresses this device's own address while select is high
      select_n <= 1'b1;
      probe(htrc_pkg::SLAVE_ADDR, 1'b1);
      select_n <= 1'b0;
      prev = 16'h0000;
      for (int i = 0; i < 5; i++) begin
         sample_value <= 16'ha5c3 + 16'(i * 16'h1357);
         reg_wr(htrc_pkg::ADDR_SETUP, {2'b00, i[1], i[0], 2'b00, ~i[0], 1'b1});
         chk({4'h0, meas_fast, meas_temp, warming_element_on, converting}, {4'h0, i[1], i[0], ~i[0], 1'b1});
         reg_rd(htrc_pkg::ADDR_STATUS, 1'b0, st, lo);
         chk(st, 8'h01);
         reg_rd(htrc_pkg::ADDR_MEAS_HIGH, 1'b0, st, lo);
         chk(st, prev[15:8]);
         wait_idle();
         @(posedge clk_sys);
         // the first start interrupts the reset busy period, so its length is not known
         if (i > 0) chk({7'h00, last_len == (i[1] ? FC : NC) || last_len == (i[1] ? FC : NC) + 1}, 8'h01);
         reg_rd(htrc_pkg::ADDR_STATUS, 1'b0, st, lo);
         chk(st, 8'h00);
         reg_rd(htrc_pkg::ADDR_MEAS_HIGH, 1'b1, hi, lo);
         chk(hi, sample_value[15:8]);
         chk(lo, sample_value[7:0]);
         prev = sample_value;
      end
      reg_wr(htrc_pkg::ADDR_SETUP, 8'h32);
      reg_rd(htrc_pkg::ADDR_SETUP, 1'b0, st, lo);
      chk(st, 8'h32);
      reg_rd(htrc_pkg::ADDR_STATUS, 1'b0, st, lo);
      chk(st, 8'h00);
      chk({7'h00, converting}, 8'h00);
      print_verdict();
   end
endmodule : tb_htrc_top
